// File: pwm_chan_if.sv
interface pwm_chan_if;
  logic start;
  logic manual;
  logic auto_reload;
  logic invert;
  logic [3:0] clk_sel;
  logic [15:0] cnt_buf;
  logic [15:0] cmp_buf;
  logic pre_tick;
  logic ext_edge;
  logic [15:0] count;
  logic pwm;
  logic zero_evt;
  modport ctrl (output start, manual, auto_reload, invert, clk_sel, cnt_buf, cmp_buf,
    pre_tick, ext_edge, input count, pwm, zero_evt);
  modport chan (input start, manual, auto_reload, invert, clk_sel, cnt_buf, cmp_buf,
    pre_tick, ext_edge, output count, pwm, zero_evt);
endinterface

// File: pwm_channel.sv
module pwm_channel (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  pwm_chan_if.chan ch
);
  logic [3:0] div_cnt;
  logic [15:0] cmp;
  logic [15:0] next_count;
  logic [15:0] next_cmp;
  logic next_zero;

  // Divider 2/4/8/16 from the prescaled tick, or the external clock edge
  wire use_ext = (ch.clk_sel[3:2] == pwm_timer_pkg::SEL_EXT);
  wire [4:0] mask_wide = (5'h02 << ch.clk_sel[1:0]) - 5'h01;
  wire [3:0] div_mask = mask_wide[3:0];
  wire div_tick = ch.pre_tick && ((div_cnt & div_mask) == div_mask);
  wire tick = use_ext ? ch.ext_edge : div_tick;
  wire run_tick = ch.start && tick && !ch.manual;
  wire at_zero = (ch.count == pwm_timer_pkg::COUNT_ZERO);

  // Buffers only reach the working registers on update or reload
  always_comb begin
    next_count = ch.count;
    next_cmp = cmp;
    next_zero = 1'b0;
    if (ch.manual) begin
      next_count = ch.cnt_buf;
      next_cmp = ch.cmp_buf;
    end else if (run_tick && at_zero && ch.auto_reload) begin
      next_count = ch.cnt_buf;
      next_cmp = ch.cmp_buf;
    end else if (run_tick && !at_zero) begin
      next_count = ch.count - pwm_timer_pkg::COUNT_ONE;
      next_zero = (ch.count == pwm_timer_pkg::COUNT_ONE);
    end
  end

  // Output is high while count <= compare, flipped by the inverter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 4'h0;
      ch.count <= 16'h0000;
      cmp <= 16'h0000;
      ch.zero_evt <= 1'b0;
      ch.pwm <= 1'b0;
    end else if (ce_i) begin
      if (ch.pre_tick) begin
        div_cnt <= div_cnt + 4'h1;
      end
      ch.count <= next_count;
      cmp <= next_cmp;
      ch.zero_evt <= next_zero;
      ch.pwm <= (next_count <= next_cmp) ^ ch.invert;
    end
  end

  a_manual_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && ch.manual |=> ch.count == $past(ch.cnt_buf) && cmp == $past(ch.cmp_buf))
    else $error("manual update did not load both buffers");
  a_one_shot_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !ch.manual && !ch.auto_reload && at_zero |=> at_zero)
    else $error("one-shot counter left zero");
  a_auto_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && run_tick && at_zero && ch.auto_reload |=> ch.count == $past(ch.cnt_buf))
    else $error("auto reload missed");
  a_halt_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !ch.start && !ch.manual |=> $stable(ch.count) && $stable(cmp))
    else $error("stopped timer changed its counter");
  a_invert_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && rst_n_i ##1 1'b1 |-> ch.pwm == ((ch.count <= cmp) ^ $past(ch.invert)))
    else $error("output level does not follow compare and inverter");
  c_reload: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    run_tick && at_zero && ch.auto_reload);
  c_manual: cover property (@(posedge clk_i) disable iff (!rst_n_i) ce_i && ch.manual);
endmodule

// File: pwm_timer_control_regs.sv
// Implementation choice: strobed register access.
module pwm_timer_control_regs (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic ext_clk_a_i,
  input wire logic dma_ack_i,
  output logic [1:0] pwm_o,
  output logic [1:0] irq_o,
  output logic dma_req_o,
  output logic dead_zone_en_o
);
  localparam int N = pwm_timer_pkg::NUM_CH;

  logic rst_meta;
  logic rst_n;
  logic [31:0] prescale_cfg;
  logic [31:0] clock_select_dma_config;
  logic [31:0] timer_control;
  logic [15:0] count_reload_buffer [N];
  logic [15:0] compare_reload_buffer [N];
  logic [7:0] pre_cnt;
  logic ext_a_q;
  logic [N-1:0] zero_evt;
  logic [N-1:0] to_dma;
  logic [15:0] count_readback [N];
  logic [N-1:0] hit_cntb;
  logic [N-1:0] hit_cmpb;
  logic [N-1:0] hit_rb;
  logic [31:0] rb_word [N];
  logic [31:0] buf_word [N];

  // Reset release through two flops; the first is seen only by the second
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Address decode
  wire hit_pre = (addr_i == pwm_timer_pkg::ADDR_PRESCALE);
  wire hit_cfg = (addr_i == pwm_timer_pkg::ADDR_CLKCFG);
  wire hit_ctl = (addr_i == pwm_timer_pkg::ADDR_CONTROL);
  wire wr_pre = ce_i && wr_i && hit_pre;
  wire wr_cfg = ce_i && wr_i && hit_cfg;
  wire wr_ctl = ce_i && wr_i && hit_ctl;

  // Reserved bits are masked away on write, so they always read zero
  wire [31:0] pre_wval = wdata_i & pwm_timer_pkg::MASK_PRESCALE;
  wire [31:0] cfg_wval = wdata_i & pwm_timer_pkg::MASK_CLKCFG;
  // Timer 2-4 bits, including the count-only update bit of timer 4, are stored only
  wire [31:0] ctl_wval = wdata_i & pwm_timer_pkg::MASK_CONTROL;

  // Configuration and control words; all reset to zero
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prescale_cfg <= pwm_timer_pkg::RESET_WORD;
      clock_select_dma_config <= pwm_timer_pkg::RESET_WORD;
      timer_control <= pwm_timer_pkg::RESET_WORD;
    end else begin
      if (wr_pre) begin
        prescale_cfg <= pre_wval;
      end
      if (wr_cfg) begin
        clock_select_dma_config <= cfg_wval;
      end
      if (wr_ctl) begin
        timer_control <= ctl_wval;
      end
    end
  end

  // Shared prescaler for timers 0 and 1: one tick every prescale+1 cycles
  // Compared with >= so that lowering the prescale value never waits for a wrap
  wire [7:0] prescale0 = prescale_cfg[pwm_timer_pkg::PRESCALE0_LSB +: 8];
  wire pre_tick = ce_i && (pre_cnt >= prescale0);
  wire ext_edge = ext_clk_a_i && !ext_a_q;
  wire [3:0] dma_sel = clock_select_dma_config[pwm_timer_pkg::DMA_SEL_LSB +: 4];

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 8'h00;
      ext_a_q <= 1'b0;
    end else if (ce_i) begin
      pre_cnt <= pre_tick ? 8'h00 : pre_cnt + 8'h01;
      ext_a_q <= ext_clk_a_i;
    end
  end

  // One counting channel per implemented timer
  for (genvar i = 0; i < N; i++) begin : g_ch
    localparam int B = pwm_timer_pkg::CTRL_BASE[i];
    pwm_chan_if chan_bus ();

    assign chan_bus.start = timer_control[B + pwm_timer_pkg::START_OFS];
    assign chan_bus.manual = timer_control[B + pwm_timer_pkg::MANUAL_OFS];
    assign chan_bus.auto_reload = timer_control[B + pwm_timer_pkg::AUTO_OFS];
    assign chan_bus.invert = timer_control[B + pwm_timer_pkg::INVERT_OFS];
    assign chan_bus.clk_sel = clock_select_dma_config[i*pwm_timer_pkg::CLK_SEL_W +: 4];
    assign chan_bus.cnt_buf = count_reload_buffer[i];
    assign chan_bus.cmp_buf = compare_reload_buffer[i];
    assign chan_bus.pre_tick = pre_tick;
    assign chan_bus.ext_edge = ext_edge;
    assign count_readback[i] = chan_bus.count;
    assign zero_evt[i] = chan_bus.zero_evt;
    assign pwm_o[i] = chan_bus.pwm;

    // Event goes to DMA when this timer is the selected one
    assign to_dma[i] = zero_evt[i] && (dma_sel == pwm_timer_pkg::DMA_CODE[i]);

    // Per-timer decode
    assign hit_cntb[i] = (addr_i == pwm_timer_pkg::ADDR_CNTB[i]);
    assign hit_cmpb[i] = (addr_i == pwm_timer_pkg::ADDR_CMPB[i]);
    assign hit_rb[i] = (addr_i == pwm_timer_pkg::ADDR_READBACK[i]);
    assign rb_word[i] = hit_rb[i] ? {16'h0000, count_readback[i]} : 32'h00000000;
    assign buf_word[i] = hit_cntb[i] ? {16'h0000, count_reload_buffer[i]} :
                         hit_cmpb[i] ? {16'h0000, compare_reload_buffer[i]} : 32'h00000000;

    // Buffer writes touch only the buffers, never the running counter
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        count_reload_buffer[i] <= 16'h0000;
        compare_reload_buffer[i] <= 16'h0000;
      end else if (ce_i && wr_i) begin
        if (hit_cntb[i]) begin
          count_reload_buffer[i] <= wdata_i[15:0];
        end
        if (hit_cmpb[i]) begin
          compare_reload_buffer[i] <= wdata_i[15:0];
        end
      end
    end

    pwm_channel u_channel (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .ch(chan_bus.chan)
    );
  end

  // Read mux; unmapped addresses answer zero
  wire [31:0] read_word = hit_pre ? prescale_cfg :
                          hit_cfg ? clock_select_dma_config :
                          hit_ctl ? timer_control :
                          (rb_word[0] | rb_word[1] | buf_word[0] | buf_word[1]);
  wire dma_set = |to_dma;
  wire [N-1:0] next_irq = zero_evt & ~to_dma;

  // Read data appears the cycle after the strobe and only then
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      rdata_o <= rd_i ? read_word : 32'h00000000;
    end
  end

  // Interrupt pulses and a DMA request held until acknowledged; set beats ack
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 2'h0;
      dma_req_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= next_irq;
      dma_req_o <= dma_set || (dma_req_o && !dma_ack_i);
    end
  end

  // Dead zone waveform lives outside; the enable is only exported
  assign dead_zone_en_o = timer_control[pwm_timer_pkg::DEAD_ZONE_BIT];

  a_ctrl_write_mask: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    wr_ctl |=> timer_control == ($past(wdata_i) & pwm_timer_pkg::MASK_CONTROL))
    else $error("control write not stored through reserved mask");
  a_cfg_write_mask: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    wr_cfg |=> clock_select_dma_config == ($past(wdata_i) & pwm_timer_pkg::MASK_CLKCFG))
    else $error("clock config write not stored");
  a_read_timing: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ce_i && rd_i && hit_ctl |=> rdata_o == $past(timer_control))
    else $error("control readback wrong");
  a_readback_live: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ce_i && rd_i && hit_rb[0] |=> rdata_o == {16'h0000, $past(count_readback[0])})
    else $error("count readback not live");
  a_buffer_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ce_i && wr_i && hit_cmpb[0] |=> compare_reload_buffer[0] == $past(wdata_i[15:0]))
    else $error("compare buffer write lost");
  a_dma_route: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ce_i && to_dma[0] |=> dma_req_o && !irq_o[0])
    else $error("selected timer raised interrupt instead of DMA");
  a_irq_route: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ce_i && zero_evt[1] && dma_sel == pwm_timer_pkg::DMA_NONE |=> irq_o[1])
    else $error("unselected timer lost its interrupt");
  a_read_idle_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ce_i && !rd_i |=> rdata_o == 32'h00000000)
    else $error("read data outside the answer cycle");
  c_dma_request: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    dma_req_o ##1 dma_ack_i);
  c_readback: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    rd_i && hit_rb[0]);
  c_interrupt: cover property (@(posedge ref_clk_i) disable iff (!rst_n) irq_o[0]);
endmodule

// File: pwm_timer_pkg.sv
package pwm_timer_pkg;
  localparam int NUM_CH = 2;
  // Byte addresses of the register map
  localparam logic [31:0] ADDR_PRESCALE = 32'h51000000;
  localparam logic [31:0] ADDR_CLKCFG = 32'h51000004;
  localparam logic [31:0] ADDR_CONTROL = 32'h51000008;
  localparam logic [31:0] ADDR_CNTB[NUM_CH] = '{32'h5100000c, 32'h51000018};
  localparam logic [31:0] ADDR_CMPB[NUM_CH] = '{32'h51000010, 32'h5100001c};
  localparam logic [31:0] ADDR_READBACK[NUM_CH] = '{32'h51000014, 32'h51000020};
  // Writable bit masks; everything else is reserved
  localparam logic [31:0] MASK_PRESCALE = 32'h00ffffff;
  localparam logic [31:0] MASK_CLKCFG = 32'h00ffffff;
  localparam logic [31:0] MASK_CONTROL = 32'h007fff1f;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  // Field positions
  localparam int PRESCALE0_LSB = 0;
  localparam int DMA_SEL_LSB = 20;
  localparam int CLK_SEL_W = 4;
  localparam int DEAD_ZONE_BIT = 4;
  localparam int CTRL_BASE[NUM_CH] = '{0, 8};
  localparam int START_OFS = 0;
  localparam int MANUAL_OFS = 1;
  localparam int INVERT_OFS = 2;
  localparam int AUTO_OFS = 3;
  // Clock select and DMA codes
  localparam logic [1:0] SEL_EXT = 2'h1;
  localparam logic [3:0] DMA_NONE = 4'h0;
  localparam logic [3:0] DMA_CODE[NUM_CH] = '{4'h1, 4'h2};
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
endpackage

// File: test_pwm_timer_control_regs.sv
module test_pwm_timer_control_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i, rstn_i, ce_i, wr_i, rd_i, ext_clk_a_i, dma_ack_i;
  logic [31:0] addr_i, wdata_i, rdata_o, rd_val;
  logic [1:0] pwm_o, irq_o;
  logic dma_req_o, dead_zone_en_o;
  int n_mismatch, samples_checked;
  // Writable registers and the bits that must read back after writing all ones
  localparam logic [31:0] rw_addr[7] = '{pwm_timer_pkg::ADDR_PRESCALE,
    pwm_timer_pkg::ADDR_CLKCFG, pwm_timer_pkg::ADDR_CNTB[0], pwm_timer_pkg::ADDR_CMPB[0],
    pwm_timer_pkg::ADDR_CNTB[1], pwm_timer_pkg::ADDR_CMPB[1], pwm_timer_pkg::ADDR_CONTROL};
  localparam logic [31:0] rw_mask[7] = '{32'h00ffffff, 32'h00ffffff, 32'h0000ffff,
    32'h0000ffff, 32'h0000ffff, 32'h0000ffff, 32'h007fff1f};

  pwm_timer_control_regs uut (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .ext_clk_a_i(ext_clk_a_i),
    .dma_ack_i(dma_ack_i),
    .pwm_o(pwm_o),
    .irq_o(irq_o),
    .dma_req_o(dma_req_o),
    .dead_zone_en_o(dead_zone_en_o)
  );

  // 10 MHz bus clock
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_sim;
    $display("Counts: %0d mismatches in %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Unknown operands make the comparison unknown, which counts as a miss
  task automatic chk_le(input logic [31:0] got, input logic [31:0] lim, input string what);
    samples_checked++;
    if ((got <= lim) !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s value %h above %h", $time, what, got, lim);
    end
  endtask

  // Bus write: one cycle strobe, changed just after the edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  // Bus read: data stands only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic chk_reg(input logic [31:0] a, input logic [31:0] exp, input string what);
    rd(a, rd_val);
    chk(rd_val, exp, what);
  endtask

  // Bounded wait for an interrupt pulse or a DMA request
  task automatic wait_evt(input int ch, input int limit);
    int cyc;
    cyc = 0;
    #1;
    while (irq_o[ch] !== 1'b1 && dma_req_o !== 1'b1) begin
      if (cyc >= limit) begin
        n_mismatch++;
        $display("MISMATCH at %0t: timer event missing", $time);
        end_sim;
      end
      @(posedge ref_clk_i);
      #1 cyc++;
    end
  endtask

  task automatic pulse_ext;
    @(posedge ref_clk_i);
    ext_clk_a_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    ext_clk_a_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask

  // One timer run: code c sets DMA select, divider, prescaler and the timer used
  task automatic run(input int c);
    int ch, sh, div, cyc;
    time t0;
    logic [31:0] ctl;
    ch = (c == 0 || c == 2) ? 1 : 0;
    sh = pwm_timer_pkg::CTRL_BASE[ch];
    div = (c % 2 + 1) * (2 << (c % 4));
    ctl = (c == 6) ? 32'h9 : 32'h1;
    wr(pwm_timer_pkg::ADDR_PRESCALE, 32'(c % 2));
    wr(pwm_timer_pkg::ADDR_CLKCFG, (32'(c) << 20) | (32'(c % 4) << (4 * ch)));
    wr(pwm_timer_pkg::ADDR_CNTB[ch], 32'h8);
    wr(pwm_timer_pkg::ADDR_CMPB[ch], 32'h1);
    wr(pwm_timer_pkg::ADDR_CONTROL, 32'h2 << sh);
    t0 = $time;
    wr(pwm_timer_pkg::ADDR_CONTROL, ctl << sh);
    // A new buffer value must wait for the next reload
    wr(pwm_timer_pkg::ADDR_CNTB[ch], 32'h9);
    rd(pwm_timer_pkg::ADDR_READBACK[ch], rd_val);
    chk_le(rd_val, 32'h8, "count while running");
    wait_evt(ch, 400);
    cyc = int'(($time - t0) / 100);
    chk_le(32'(7 * div), 32'(cyc), "event too early");
    chk_le(32'(cyc), 32'(9 * div + 8), "event too late");
    chk({31'h0, dma_req_o}, {31'h0, c == ch + 1}, "dma request");
    chk({31'h0, irq_o[ch]}, {31'h0, c != ch + 1}, "interrupt");
    if (c == ch + 1) begin
      @(posedge ref_clk_i);
      dma_ack_i <= 1'b1;
      @(posedge ref_clk_i);
      dma_ack_i <= 1'b0;
      @(posedge ref_clk_i);
      #1 chk({31'h0, dma_req_o}, 32'h0, "dma after ack");
    end
    if (c == 6) begin
      // Interval mode: reload from the buffer written while running
      @(posedge ref_clk_i);
      wait_evt(ch, 12 * div);
    end else begin
      repeat (3 * div) @(posedge ref_clk_i);
      chk_reg(pwm_timer_pkg::ADDR_READBACK[ch], 32'h0, "one-shot stop");
      chk({31'h0, pwm_o[ch]}, 32'h1, "pwm level");
      wr(pwm_timer_pkg::ADDR_CONTROL, (ctl | 32'h4) << sh);
      @(posedge ref_clk_i);
      #1 chk({31'h0, pwm_o[ch]}, 32'h0, "inverted pwm");
    end
    wr(pwm_timer_pkg::ADDR_CONTROL, 32'h0);
  endtask

  initial begin
    ce_i = 1'b1;
    rstn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 32'h0;
    wdata_i = 32'h0;
    ext_clk_a_i = 1'b0;
    dma_ack_i = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (8) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 7; i++) begin
      chk_reg(rw_addr[i], 32'h0, "reset value");
    end
    chk_reg(pwm_timer_pkg::ADDR_READBACK[0], 32'h0, "readback reset");
    // Read-only and unmapped places ignore writes
    wr(pwm_timer_pkg::ADDR_READBACK[0], 32'hffffffff);
    chk_reg(pwm_timer_pkg::ADDR_READBACK[0], 32'h0, "readback written");
    wr(32'h51000044, 32'hffffffff);
    chk_reg(32'h51000044, 32'h0, "unmapped read");
    for (int i = 0; i < 7; i++) begin
      wr(rw_addr[i], 32'hffffffff);
      chk_reg(rw_addr[i], rw_mask[i], "masked write");
    end
    chk({31'h0, dead_zone_en_o}, 32'h1, "dead zone on");
    wr(pwm_timer_pkg::ADDR_CONTROL, 32'h0);
    #1 chk({31'h0, dead_zone_en_o}, 32'h0, "dead zone off");
    for (int i = 0; i < 6; i++) begin
      wr(rw_addr[i], 32'h0);
    end
    for (int c = 0; c < 7; c++) begin
      run(c);
    end
    // External clock A drives timer 0: no edge, no count
    wr(pwm_timer_pkg::ADDR_CLKCFG, 32'h4);
    wr(pwm_timer_pkg::ADDR_CNTB[0], 32'h2);
    wr(pwm_timer_pkg::ADDR_CONTROL, 32'h2);
    wr(pwm_timer_pkg::ADDR_CONTROL, 32'h1);
    repeat (20) @(posedge ref_clk_i);
    chk_reg(pwm_timer_pkg::ADDR_READBACK[0], 32'h2, "no external edge");
    pulse_ext;
    chk_reg(pwm_timer_pkg::ADDR_READBACK[0], 32'h1, "one external edge");
    // A pulse while the clock enable is low must leave all state frozen
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    pulse_ext;
    ce_i <= 1'b1;
    chk_reg(pwm_timer_pkg::ADDR_READBACK[0], 32'h1, "frozen by clock enable");
    // Last edge: the one-cycle interrupt pulse is watched as it comes
    @(posedge ref_clk_i);
    ext_clk_a_i <= 1'b1;
    wait_evt(0, 4);
    chk({31'h0, irq_o[0]}, 32'h1, "external zero event");
    end_sim;
  end
endmodule
